// *** src/dtc_timer.sv ***
// Dual 8/16-bit timer/event counter with AXI4-Lite register access.
// Assumes one clock mclk at 125 MHz; count and gate pins are asynchronous.
// What this block does
// [R1] Timer 0 uses low mode nibble, control bits 5,4
// [R2] Run bit without gate lets count advance
// [R3] Gate and run: gate pin permits counting
// [R4] Timer 0 rollover sets timer 0 overflow flag
// [R5] Mode 0: five-bit prescaler feeding high byte
// [R6] Mode 1: low and high cascade, 16 bits
// [R7] Mode 2: low counts, reloads from high
// [R8] Overflow flag cleared when interrupt serviced
// [R9] Mode 3: timer 0 low is normal 8-bit
// [R10] Mode 3: timer 0 high counts clock/6, uses timer 1 bits
// [R11] Timer 1 modes 0-2 as timer 0; 3 holds
// [R12] Timer 1 uses high mode nibble, bits 7,6
// [R13] Timer 1 rollover sets timer 1 overflow flag, except while timer 0 is split
// [R14] Firmware toggles timer 1 mode 3 while split
// [R15] Count source: divided clock or falling pin edges
// [R16] Mode field: 00 13-bit, 01 16-bit, 10 reload
// [R17] Timer 1 mode 11 halts, keeps count
// [R18] Timer operation advances at clock divided by six
// [R19] Count pins synchronised, one count per edge
// [R20] Gated counting only while gate pin high
`timescale 1ns/1ps
`default_nettype none

module dtc_timer (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic extCountPinZero,
    input wire logic extCountPinOne,
    input wire logic extGatePinZero,
    input wire logic extGatePinOne,
    input wire logic tZeroIrqAck,
    input wire logic tOneIrqAck,
    output logic tZeroOverflowIrq,
    output logic tOneOverflowIrq
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    // Pin order in the sync vectors: t_one_gate_select, t_zero_gate_select, count1, count0
    typedef struct packed {
        logic [3:0] syncA;
        logic [3:0] syncB;
        logic [3:0] syncC;
        logic [3:0] pinLevel;
        logic [2:0] divCount;
        logic [7:0] modeCfg;
        logic [7:0] ctrl;
        logic [7:0] tZeroLow;
        logic [7:0] tZeroHigh;
        logic [7:0] tOneLow;
        logic [7:0] tOneHigh;
        logic awHeld;
        logic [7:0] awIdx;
        logic wHeld;
        logic [7:0] wByte;
        logic wLane0;
        logic bValid;
        logic [1:0] bResp;
        logic rValid;
        logic [7:0] rByte;
        logic [1:0] rResp;
    } dtc_state_t;

    dtc_state_t st_reg;
    dtc_state_t st_next;

    // Increment one timer by one event in a given mode.
    // Returns {overflow, high, low}.
    function automatic logic [16:0] dtcStep(
        input logic [1:0] md,
        input logic [7:0] lo,
        input logic [7:0] hi
    );
        logic [16:0] res;
        res = {1'b0, hi, lo};
        case (md)
            dtc_pkg::DTC_M13: begin
                // Upper three low bits are left as they are
                res[dtc_pkg::PRE_W-1:0] = lo[dtc_pkg::PRE_W-1:0] + 5'h1; // [R5]
                if (lo[dtc_pkg::PRE_W-1:0] == dtc_pkg::PRE_MAX) begin
                    res[15:8] = hi + 8'h1; // [R5]
                    res[16] = (hi == dtc_pkg::BYTE_MAX);
                end
            end
            dtc_pkg::DTC_M16: begin
                res[7:0] = lo + 8'h1; // [R6]
                if (lo == dtc_pkg::BYTE_MAX) begin
                    res[15:8] = hi + 8'h1; // [R6]
                    res[16] = (hi == dtc_pkg::BYTE_MAX);
                end
            end
            dtc_pkg::DTC_M8R: begin
                if (lo == dtc_pkg::BYTE_MAX) begin
                    res[7:0] = hi; // [R7]
                    res[16] = 1'b1;
                end else begin
                    res[7:0] = lo + 8'h1;
                end
            end
            default: begin
                // Split mode handled by the caller
                res = {1'b0, hi, lo}; // [R17]
            end
        endcase
        return res;
    endfunction

    // ----------------------------------------
    // Bus handshakes
    // ----------------------------------------
    assign s_axi_awready = !st_reg.awHeld && !st_reg.bValid;
    assign s_axi_wready = !st_reg.wHeld && !st_reg.bValid;
    assign s_axi_arready = !st_reg.rValid;
    assign s_axi_bvalid = st_reg.bValid;
    assign s_axi_bresp = st_reg.bResp;
    assign s_axi_rvalid = st_reg.rValid;
    assign s_axi_rresp = st_reg.rResp;
    assign s_axi_rdata = {24'h000000, st_reg.rByte};
    assign tZeroOverflowIrq = st_reg.ctrl[dtc_pkg::C_TF0]; // [R4]
    assign tOneOverflowIrq = st_reg.ctrl[dtc_pkg::C_TF1]; // [R13]

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        logic [3:0] fallEdge;
        logic tick;
        logic [1:0] modeZero;
        logic [1:0] modeOne;
        logic split;
        logic runZero;
        logic runOne;
        logic incZero;
        logic incOne;
        logic incSplitHigh;
        logic [16:0] stepZero;
        logic [16:0] stepOne;
        logic setTf0;
        logic setTf1;
        logic doWrite;
        logic [7:0] arIdx;
        logic [7:0] rdVal;
        logic rdHit;

        st_next = st_reg;

        // Three-stage sync; level moves once stages two and three agree
        st_next.syncA = {extGatePinOne, extGatePinZero, extCountPinOne, extCountPinZero};
        st_next.syncB = st_reg.syncA;
        st_next.syncC = st_reg.syncB;
        fallEdge = 4'h0;
        for (int i = 0; i < 4; i++) begin
            if (st_reg.syncB[i] == st_reg.syncC[i]) begin
                st_next.pinLevel[i] = st_reg.syncC[i]; // [R19]
                fallEdge[i] = st_reg.pinLevel[i] && !st_reg.syncC[i]; // [R19]
            end
        end

        // Divide by six for timer operation
        tick = (st_reg.divCount == dtc_pkg::DIV_LAST); // [R18]
        st_next.divCount = tick ? dtc_pkg::DIV_ZERO : st_reg.divCount + 3'h1;

        modeZero = st_reg.modeCfg[dtc_pkg::M_MODE0_LSB +: 2]; // [R1]
        modeOne = st_reg.modeCfg[dtc_pkg::M_MODE1_LSB +: 2]; // [R12]
        split = (modeZero == dtc_pkg::DTC_MSPLIT);

        // Gate bit clear: run bit alone; set: gate pin must be high too
        runZero = st_reg.ctrl[dtc_pkg::C_TR0]
            && (!st_reg.modeCfg[dtc_pkg::M_T_ZERO_GATE_SELECT] || st_reg.pinLevel[2]); // [R2] [R3] [R20]
        // Timer 0 split borrows the timer 1 run bit, so timer 1 then free-runs
        runOne = (split || st_reg.ctrl[dtc_pkg::C_TR1])
            && (!st_reg.modeCfg[dtc_pkg::M_T_ONE_GATE_SELECT] || st_reg.pinLevel[3]); // [R3] [R14] [R20]
        incZero = runZero && (st_reg.modeCfg[dtc_pkg::M_CS0] ? fallEdge[0] : tick); // [R15]
        incOne = runOne && (st_reg.modeCfg[dtc_pkg::M_CS1] ? fallEdge[1] : tick); // [R15]
        incSplitHigh = split && st_reg.ctrl[dtc_pkg::C_TR1] && tick; // [R10]

        setTf0 = 1'b0;
        setTf1 = 1'b0;
        stepZero = dtcStep(modeZero, st_reg.tZeroLow, st_reg.tZeroHigh); // [R16]
        stepOne = dtcStep(modeOne, st_reg.tOneLow, st_reg.tOneHigh); // [R11]

        // Timer 0
        if (split) begin
            if (incZero) begin
                st_next.tZeroLow = st_reg.tZeroLow + 8'h1; // [R9]
                setTf0 = (st_reg.tZeroLow == dtc_pkg::BYTE_MAX); // [R9]
            end
            if (incSplitHigh) begin
                st_next.tZeroHigh = st_reg.tZeroHigh + 8'h1; // [R10]
                setTf1 = (st_reg.tZeroHigh == dtc_pkg::BYTE_MAX); // [R10]
            end
        end else if (incZero) begin
            st_next.tZeroLow = stepZero[7:0];
            st_next.tZeroHigh = stepZero[15:8];
            setTf0 = stepZero[16]; // [R4]
        end

        // Timer 1; mode 3 holds the count
        if (incOne && modeOne != dtc_pkg::DTC_MSPLIT) begin
            st_next.tOneLow = stepOne[7:0];
            st_next.tOneHigh = stepOne[15:8];
            // Flag belongs to timer 0 high while split
            if (!split) begin
                setTf1 = stepOne[16]; // [R13]
            end
        end

        // Service acknowledge clears the flag
        if (tZeroIrqAck) begin
            st_next.ctrl[dtc_pkg::C_TF0] = 1'b0; // [R8]
        end
        if (tOneIrqAck) begin
            st_next.ctrl[dtc_pkg::C_TF1] = 1'b0; // [R8]
        end

        // Write channels: address and data captured in either order
        if (s_axi_awvalid && s_axi_awready) begin
            st_next.awHeld = 1'b1;
            st_next.awIdx = s_axi_awaddr[dtc_pkg::IDX_LSB +: 8];
        end
        if (s_axi_wvalid && s_axi_wready) begin
            st_next.wHeld = 1'b1;
            st_next.wByte = s_axi_wdata[7:0];
            st_next.wLane0 = s_axi_wstrb[0];
        end
        doWrite = st_reg.awHeld && st_reg.wHeld && !st_reg.bValid;
        if (doWrite) begin
            st_next.awHeld = 1'b0;
            st_next.wHeld = 1'b0;
            st_next.bValid = 1'b1;
            st_next.bResp = dtc_pkg::RESP_OKAY;
            if (st_reg.awIdx == dtc_pkg::IDX_CTRL) begin
                if (st_reg.wLane0) begin
                    st_next.ctrl = st_reg.wByte;
                end
            end else if (st_reg.awIdx == dtc_pkg::IDX_MODE) begin
                if (st_reg.wLane0) begin
                    st_next.modeCfg = st_reg.wByte;
                end
            end else if (st_reg.awIdx == dtc_pkg::IDX_TL0) begin
                if (st_reg.wLane0) begin
                    st_next.tZeroLow = st_reg.wByte;
                end
            end else if (st_reg.awIdx == dtc_pkg::IDX_TL1) begin
                if (st_reg.wLane0) begin
                    st_next.tOneLow = st_reg.wByte;
                end
            end else if (st_reg.awIdx == dtc_pkg::IDX_TH0) begin
                if (st_reg.wLane0) begin
                    st_next.tZeroHigh = st_reg.wByte;
                end
            end else if (st_reg.awIdx == dtc_pkg::IDX_TH1) begin
                if (st_reg.wLane0) begin
                    st_next.tOneHigh = st_reg.wByte;
                end
            end else begin
                st_next.bResp = dtc_pkg::RESP_SLVERR;
            end
        end
        if (st_reg.bValid && s_axi_bready) begin
            st_next.bValid = 1'b0;
        end

        // Hardware set wins over any clear in the same cycle
        if (setTf0) begin
            st_next.ctrl[dtc_pkg::C_TF0] = 1'b1; // [R4]
        end
        if (setTf1) begin
            st_next.ctrl[dtc_pkg::C_TF1] = 1'b1; // [R13]
        end

        // Read channel
        arIdx = s_axi_araddr[dtc_pkg::IDX_LSB +: 8];
        rdHit = 1'b1;
        if (arIdx == dtc_pkg::IDX_CTRL) begin
            rdVal = st_reg.ctrl;
        end else if (arIdx == dtc_pkg::IDX_MODE) begin
            rdVal = st_reg.modeCfg;
        end else if (arIdx == dtc_pkg::IDX_TL0) begin
            rdVal = st_reg.tZeroLow;
        end else if (arIdx == dtc_pkg::IDX_TL1) begin
            rdVal = st_reg.tOneLow;
        end else if (arIdx == dtc_pkg::IDX_TH0) begin
            rdVal = st_reg.tZeroHigh;
        end else if (arIdx == dtc_pkg::IDX_TH1) begin
            rdVal = st_reg.tOneHigh;
        end else begin
            rdVal = 8'h00;
            rdHit = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            st_next.rValid = 1'b1;
            st_next.rByte = rdVal;
            st_next.rResp = rdHit ? dtc_pkg::RESP_OKAY : dtc_pkg::RESP_SLVERR;
        end else if (st_reg.rValid && s_axi_rready) begin
            st_next.rValid = 1'b0;
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            st_reg <= '0;
            st_reg.modeCfg <= dtc_pkg::MODE_RST;
            st_reg.ctrl <= dtc_pkg::CTRL_RST;
            st_reg.tZeroLow <= dtc_pkg::COUNT_RST;
            st_reg.tZeroHigh <= dtc_pkg::COUNT_RST;
            st_reg.tOneLow <= dtc_pkg::COUNT_RST;
            st_reg.tOneHigh <= dtc_pkg::COUNT_RST;
        end else begin
            st_reg <= st_next;
        end
    end
endmodule

`default_nettype wire

// *** inc/dtc_pkg.sv ***
// Package for the dual timer/counter block: register indices, field
// positions, reset values and timing constants.
// Assumes a 125 MHz system clock and an AXI4-Lite register bus.
package dtc_pkg;
    // Register indices as printed; byte address is four times the index
    localparam logic [7:0] IDX_CTRL = 8'h88;
    localparam logic [7:0] IDX_MODE = 8'h89;
    localparam logic [7:0] IDX_TL0 = 8'h8a;
    localparam logic [7:0] IDX_TL1 = 8'h8b;
    localparam logic [7:0] IDX_TH0 = 8'h8c;
    localparam logic [7:0] IDX_TH1 = 8'h8d;
    localparam int ADDR_W = 12;
    localparam int IDX_LSB = 2;

    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] COUNT_RST = 8'h00;

    // timer_control_flags bit positions
    localparam int C_TF1 = 7;
    localparam int C_TR1 = 6;
    localparam int C_TF0 = 5;
    localparam int C_TR0 = 4;

    // timer_mode_config field positions
    localparam int M_T_ONE_GATE_SELECT = 7;
    localparam int M_CS1 = 6;
    localparam int M_MODE1_LSB = 4;
    localparam int M_T_ZERO_GATE_SELECT = 3;
    localparam int M_CS0 = 2;
    localparam int M_MODE0_LSB = 0;

    typedef enum logic [1:0] {
        DTC_M13 = 2'h0,
        DTC_M16 = 2'h1,
        DTC_M8R = 2'h2,
        DTC_MSPLIT = 2'h3
    } dtc_mode_t;

    // Prescaler: five low bits of the low register
    localparam int PRE_W = 5;
    localparam logic [4:0] PRE_MAX = 5'h1f;
    localparam logic [7:0] BYTE_MAX = 8'hff;

    // System clock divided by six for timer operation
    localparam int CLK_DIV = 6;
    localparam logic [2:0] DIV_LAST = 3'(CLK_DIV - 1);
    localparam logic [2:0] DIV_ZERO = 3'h0;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** test/dtc_timer_chk.sv ***
// Checker for the dual timer block: bus handshakes and overflow flags.
// Sees only the ports of dtc_timer; bound to it at the foot of the file.
`timescale 1ns/1ps
`default_nettype none
module dtc_timer_chk (
    input wire logic mclk,
    input wire logic reset,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic tZeroIrqAck,
    input wire logic tOneIrqAck,
    input wire logic tZeroOverflowIrq,
    input wire logic tOneOverflowIrq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    AST_AW_SHUT: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write channel open while response pending");
    AST_AR_SHUT: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read channel open while data pending");
    AST_B_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid)
        else $error("write response late");
    AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    AST_B_DROP: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    AST_R_DROP: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data repeated");
    AST_RDATA_HI: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    AST_TF0_CLR: assert property ($fell(tZeroOverflowIrq) |-> $past(tZeroIrqAck) || $rose(s_axi_bvalid))
        else $error("timer 0 flag dropped without cause");
    AST_TF1_CLR: assert property ($fell(tOneOverflowIrq) |-> $past(tOneIrqAck) || $rose(s_axi_bvalid))
        else $error("timer 1 flag dropped without cause");
endmodule
bind dtc_timer dtc_timer_chk chk (.mclk, .reset, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .tZeroIrqAck, .tOneIrqAck, .tZeroOverflowIrq, .tOneOverflowIrq);
`default_nettype wire

// *** test/dtc_pin_model.sv ***
// Far-side model: external count and gate pins of both timers.
// Driven only by its own tasks, changed just after a rising mclk edge.
`timescale 1ns/1ps
`default_nettype none
module dtc_pin_model (
    input wire logic mclk,
    output logic extCountPinZero,
    output logic extCountPinOne,
    output logic extGatePinZero,
    output logic extGatePinOne
);
    initial begin
        extCountPinZero = 1'b1;
        extCountPinOne = 1'b1;
        extGatePinZero = 1'b1;
        extGatePinOne = 1'b1;
    end
    // Low and high four cycles each, so the synchroniser sees one clean edge
    task automatic pulse(input int which);
        @(posedge mclk);
        if (which == 0) extCountPinZero <= 1'b0; else extCountPinOne <= 1'b0;
        repeat (4) @(posedge mclk);
        if (which == 0) extCountPinZero <= 1'b1; else extCountPinOne <= 1'b1;
        repeat (4) @(posedge mclk);
    endtask
    // Extra cycles let the level pass the synchroniser before it is relied on
    task automatic gate(input int which, input logic lvl);
        @(posedge mclk);
        if (which == 0) extGatePinZero <= lvl; else extGatePinOne <= lvl;
        repeat (4) @(posedge mclk);
    endtask
endmodule
`default_nettype wire

// *** test/dual_timer_counter_0_1_test.sv ***
// Self-checking bench for the dual timer block over AXI4-Lite.
// Assumes dtc_pkg and dtc_timer are compiled first; pin model at far side.
`timescale 1ns/1ps
`default_nettype none
module dual_timer_counter_0_1_test;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_bready = 1'b1, s_axi_rready = 1'b1, tZeroIrqAck = 1'b0, tOneIrqAck = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic tZeroOverflowIrq, tOneOverflowIrq;
    logic extCountPinZero, extCountPinOne, extGatePinZero, extGatePinOne;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [31:0] s_axi_rdata;
    logic [7:0] v;
    int fail_count = 0, check_count = 0;
    time riseA = 0, riseB = 0;
    always #4 mclk = ~mclk;
    always @(posedge tOneOverflowIrq) begin
        riseA = riseB;
        riseB = $time;
    end
    dtc_timer dut (.mclk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .extCountPinZero, .extCountPinOne, .extGatePinZero,
        .extGatePinOne, .tZeroIrqAck, .tOneIrqAck, .tZeroOverflowIrq, .tOneOverflowIrq);
    dtc_pin_model far (.mclk, .extCountPinZero, .extCountPinOne, .extGatePinZero,
        .extGatePinOne);
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic guard(inout int n);
        n++;
        if (n > 300) begin
            fail_count++;
            summarize();
        end
    endtask
    // Handshakes are sampled at the falling edge, where inputs are settled
    task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er = 2'h0,
        input logic [3:0] sb = 4'hf);
        logic a, w, b;
        int n;
        a = 1'b1;
        w = 1'b1;
        b = 1'b0;
        n = 0;
        s_axi_awaddr <= {2'h0, idx, 2'h0};
        s_axi_wdata <= {24'h0, d};
        s_axi_wstrb <= sb;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!b) begin
            @(negedge mclk);
            a = a && !s_axi_awready;
            w = w && !s_axi_wready;
            b = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge mclk);
            if (!a) s_axi_awvalid <= 1'b0;
            if (!w) s_axi_wvalid <= 1'b0;
            guard(n);
        end
        check(r, er);
    endtask
    task automatic rd(input logic [7:0] idx);
        logic a, b;
        int n;
        a = 1'b1;
        b = 1'b0;
        n = 0;
        s_axi_araddr <= {2'h0, idx, 2'h0};
        s_axi_arvalid <= 1'b1;
        while (!b) begin
            @(negedge mclk);
            a = a && !s_axi_arready;
            b = s_axi_rvalid;
            v = s_axi_rdata[7:0];
            r = s_axi_rresp;
            @(posedge mclk);
            if (!a) s_axi_arvalid <= 1'b0;
            guard(n);
        end
    endtask
    task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
        rd(idx);
        check(v, exp);
    endtask
    task automatic waitIrq(input logic one);
        int n;
        n = 0;
        while ((one ? tOneOverflowIrq : tZeroOverflowIrq) !== 1'b1) begin
            @(negedge mclk);
            guard(n);
        end
        @(posedge mclk);
    endtask
    task automatic ack(input logic one);
        if (one) tOneIrqAck <= 1'b1; else tZeroIrqAck <= 1'b1;
        @(posedge mclk);
        tOneIrqAck <= 1'b0;
        tZeroIrqAck <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic tRegs();
        rdc(dtc_pkg::IDX_MODE, dtc_pkg::MODE_RST);
        rdc(dtc_pkg::IDX_CTRL, dtc_pkg::CTRL_RST);
        rdc(dtc_pkg::IDX_TH1, dtc_pkg::COUNT_RST);
        // Byte lane 0 not strobed: accepted, register left alone
        wr(dtc_pkg::IDX_MODE, 8'hff, dtc_pkg::RESP_OKAY, 4'he);
        rdc(dtc_pkg::IDX_MODE, dtc_pkg::MODE_RST);
        wr(8'h90, 8'h5a, dtc_pkg::RESP_SLVERR);
        rd(8'h90);
        check({v, r}, {8'h00, dtc_pkg::RESP_SLVERR});
    endtask
    task automatic tPresc();
        wr(dtc_pkg::IDX_MODE, 8'h04);
        wr(dtc_pkg::IDX_TL0, 8'h1f);
        wr(dtc_pkg::IDX_CTRL, 8'h10);
        far.pulse(0);
        rdc(dtc_pkg::IDX_TH0, 8'h01);
        rd(dtc_pkg::IDX_TL0);
        check(v[4:0], 5'h00);
        wr(dtc_pkg::IDX_CTRL, 8'h00);
        far.pulse(0);
        rdc(dtc_pkg::IDX_TH0, 8'h01);
    endtask
    task automatic tGate();
        wr(dtc_pkg::IDX_MODE, 8'h0d);
        wr(dtc_pkg::IDX_TL0, 8'h00);
        wr(dtc_pkg::IDX_CTRL, 8'h10);
        far.gate(0, 1'b0);
        far.pulse(0);
        rdc(dtc_pkg::IDX_TL0, 8'h00);
        far.gate(0, 1'b1);
        far.pulse(0);
        rdc(dtc_pkg::IDX_TL0, 8'h01);
    endtask
    task automatic tHalt();
        wr(dtc_pkg::IDX_MODE, 8'h70);
        wr(dtc_pkg::IDX_TL1, 8'h55);
        wr(dtc_pkg::IDX_CTRL, 8'h40);
        far.pulse(1);
        rdc(dtc_pkg::IDX_TL1, 8'h55);
        wr(dtc_pkg::IDX_MODE, 8'h50);
        far.pulse(1);
        rdc(dtc_pkg::IDX_TL1, 8'h56);
    endtask
    task automatic tOvf();
        wr(dtc_pkg::IDX_MODE, 8'h01);
        wr(dtc_pkg::IDX_TL0, 8'hfe);
        wr(dtc_pkg::IDX_TH0, 8'hff);
        wr(dtc_pkg::IDX_CTRL, 8'h10);
        waitIrq(1'b0);
        wr(dtc_pkg::IDX_CTRL, 8'h20);
        rdc(dtc_pkg::IDX_TH0, 8'h00);
        rdc(dtc_pkg::IDX_CTRL, 8'h20);
        ack(1'b0);
        rdc(dtc_pkg::IDX_CTRL, 8'h00);
    endtask
    // Reload from 0xfa gives six ticks between overflows
    task automatic tReload();
        wr(dtc_pkg::IDX_MODE, 8'h20);
        wr(dtc_pkg::IDX_TH1, 8'hfa);
        wr(dtc_pkg::IDX_TL1, 8'hfe);
        wr(dtc_pkg::IDX_CTRL, 8'h40);
        waitIrq(1'b1);
        ack(1'b1);
        waitIrq(1'b1);
        check(riseB - riseA, 6 * dtc_pkg::CLK_DIV * 8);
        wr(dtc_pkg::IDX_CTRL, 8'h80);
        rdc(dtc_pkg::IDX_TH1, 8'hfa);
        rd(dtc_pkg::IDX_TL1);
        check(v[7:1], 7'h7d);
        rdc(dtc_pkg::IDX_CTRL, 8'h80);
        wr(dtc_pkg::IDX_CTRL, 8'h00);
    endtask
    task automatic tSplit();
        wr(dtc_pkg::IDX_MODE, 8'h03);
        wr(dtc_pkg::IDX_TH0, 8'hfe);
        wr(dtc_pkg::IDX_CTRL, 8'h40);
        waitIrq(1'b1);
        rdc(dtc_pkg::IDX_CTRL, 8'hc0);
        // Timer 1 has no run bit while split: mode 3 stops it, mode 1 restarts it
        wr(dtc_pkg::IDX_MODE, 8'h33);
        wr(dtc_pkg::IDX_TL1, 8'h42);
        repeat (4 * dtc_pkg::CLK_DIV) @(posedge mclk);
        rdc(dtc_pkg::IDX_TL1, 8'h42);
        wr(dtc_pkg::IDX_MODE, 8'h13);
        repeat (4 * dtc_pkg::CLK_DIV) @(posedge mclk);
        rd(dtc_pkg::IDX_TL1);
        check(v > 8'h42, 1'b1);
    endtask
    initial begin
        repeat (5) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        tRegs();
        tPresc();
        tGate();
        tHalt();
        tOvf();
        tReload();
        tSplit();
        summarize();
    end
endmodule
`default_nettype wire
